// ===== pkg/fdc_ctl_pkg.sv
// Constants for the floppy status, reset and mode logic
package fdc_ctl_pkg;
  // Second result status byte field positions
  localparam int ST2_CM_BIT = 6;
  localparam int ST2_DD_BIT = 5;
  localparam int ST2_WC_BIT = 4;
  localparam int ST2_BC_BIT = 1;
  localparam int ST2_MD_BIT = 0;
  // Third result status byte field positions
  localparam int ST3_WP_BIT = 6;
  localparam int ST3_T0_BIT = 4;
  localparam int ST3_HD_BIT = 2;
  localparam int ST3_DS_LSB = 0;
  // Fixed bits of the third byte (bits 5 and 3 high, others low)
  localparam logic [7:0] ST3_FIXED = 8'h28;
  // Track number that marks a hard-error track
  localparam logic [7:0] BAD_TRACK_NUM = 8'hFF;
  // Result byte selectors
  localparam logic RES_SEL_ST2 = 1'b0;
  localparam logic RES_SEL_ST3 = 1'b1;
  // Digital output register bit positions
  localparam int DOR_RST_BIT = 2;
  localparam int DOR_DMA_BIT = 3;
  // Data rate select register self-clearing reset bit
  localparam int DSR_RST_BIT = 7;
  // Logical device config register interface mode field
  localparam int CFG_MODE_LSB = 2;
  localparam logic [1:0] MODE_AT = 2'h3;
  localparam logic [1:0] MODE_ALT = 2'h2;
  localparam logic [1:0] MODE_M3 = 2'h1;
  // Reset values
  localparam logic [1:0] CFG_MODE_RST = 2'h3;
  localparam logic DENSITY_SELECT_OUTPUT_RST = 1'b1;
  localparam logic [7:0] BYTE_RST = 8'h00;
endpackage

// ===== design/fdc_status_reset_mode.sv
// Floppy controller result status bytes, reset sources and interface modes
`timescale 1ns/100ps
`default_nettype none
module fdc_status_reset_mode (
  input wire logic CLK_I, // 100 MHz clock
  input wire logic RSTN_I, // Hardware reset, async, low
  input wire logic DOR_WR_I, // Output register write strobe
  input wire logic [7:0] DOR_DATA_I, // Output register write data
  input wire logic DSR_WR_I, // Rate register write strobe
  input wire logic [7:0] DSR_DATA_I, // Rate register write data
  input wire logic CFG_WR_I, // Config register write strobe
  input wire logic [7:0] CFG_DATA_I, // Config register write data
  input wire logic POLL_DIS_WR_I, // Configure command polling write
  input wire logic POLL_DIS_I, // Polling disable value
  input wire logic STATUS_CLR_I, // New command clears status flags
  input wire logic READ_DELETED_I, // Command is read deleted data
  input wire logic MARK_NORMAL_I, // Pulse: normal data mark found
  input wire logic MARK_DELETED_I, // Pulse: deleted data mark found
  input wire logic MARK_MISSING_I, // Pulse: no data mark found
  input wire logic CRC_ERR_I, // Pulse: data field CRC failed
  input wire logic ID_VALID_I, // Pulse: sector ID track valid
  input wire logic [7:0] ID_TRACK_I, // Track number from sector ID
  input wire logic [7:0] CUR_TRACK_I, // Internally held track
  input wire logic WRITE_PROT_I, // Drive write protect pin
  input wire logic TRACK_ZERO_I, // Drive track zero pin
  input wire logic HEAD_SEL_I, // Head select output level
  input wire logic DRIVE_SEL_HI_I, // Drive select high line level
  input wire logic DRIVE_SEL_LO_I, // Drive select low line level
  input wire logic DENSITY_HI_I, // Core wants high density
  input wire logic RESULT_RD_I, // Result phase data read strobe
  input wire logic RESULT_SEL_I, // 0 second byte, 1 third byte
  output logic [7:0] DATA_O, // Result phase data register
  output logic [7:0] ST2_O, // Second result status byte
  output logic [7:0] ST3_O, // Third result status byte
  output logic CORE_RST_O, // Core and FIFO reset, high
  output logic PWRDN_EXIT_O, // Leave power-down; high while any soft reset is on
  output logic CFG_CLR_O, // Pulse: clear configure settings
  output logic POLL_EN_O, // Drive polling enabled
  output logic DOR_RST_O, // Output register reset bit
  output logic DMA_INT_EN_O, // Interrupt and DMA enable
  output logic DENSITY_SELECT_OUTPUT_O, // Density select pin
  output logic [1:0] MODE_O // Current interface mode
);

  // Synchroniser chains for the drive pins
  logic [1:0] pin_s1_q; // First stage, feeds second only
  logic [1:0] pin_s2_q; // Second stage
  logic [1:0] pin_s3_q; // Third stage
  logic [1:0] pin_q; // Accepted pin levels
  // Software reset and mode state
  logic dor_rst_q; // Output register reset bit
  logic dor_dma_q; // Output register DMA enable bit
  logic dsr_rst_q; // Rate register reset, one cycle
  logic [1:0] mode_q; // Interface mode field
  logic core_rst_d; // Combined soft reset
  logic core_rst_q; // Registered core reset
  // Second byte sticky flags
  logic cm_q; // control_mark_flag
  logic dd_q; // data_field_crc_error
  logic wc_q; // wrong_track_flag
  logic bc_q; // bad_track_flag
  logic md_q; // missing_data_mark_flag
  logic [7:0] st2_d; // Assembled second byte
  logic [7:0] st3_d; // Assembled third byte
  logic track_diff; // ID track differs from held track
  logic gate_d; // Interrupt and DMA enable per mode
  logic dens_d; // Density pin level per mode

  // Pin chain; the first stage is read only by the second
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
    end else begin
      pin_s1_q <= {WRITE_PROT_I, TRACK_ZERO_I};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Accept a pin change once stages two and three agree
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // Output register reset and DMA bits
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      dor_rst_q <= 1'b1;
      dor_dma_q <= 1'b0;
    end else if (DOR_WR_I) begin
      dor_rst_q <= DOR_DATA_I[fdc_ctl_pkg::DOR_RST_BIT];
      dor_dma_q <= DOR_DATA_I[fdc_ctl_pkg::DOR_DMA_BIT];
    end
  end

  // Rate register reset clears itself the next cycle
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      dsr_rst_q <= 1'b0;
    end else begin
      // Ignored while the output register reset holds the core
      dsr_rst_q <= DSR_WR_I & DSR_DATA_I[fdc_ctl_pkg::DSR_RST_BIT] & ~dor_rst_q;
    end
  end

  // Both software resets drive the same core reset
  assign core_rst_d = dor_rst_q | dsr_rst_q;

  // Core reset, power-down exit and configuration clear
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      core_rst_q <= 1'b1;
      PWRDN_EXIT_O <= 1'b1;
      CFG_CLR_O <= 1'b0;
    end else begin
      core_rst_q <= core_rst_d;
      // Any reset ends power-down
      PWRDN_EXIT_O <= core_rst_d;
      // Falling edge of core reset clears configure settings
      CFG_CLR_O <= core_rst_q & ~core_rst_d;
    end
  end

  // Polling starts on reset exit unless a configure disables it
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      POLL_EN_O <= 1'b0;
    end else if (core_rst_q) begin
      POLL_EN_O <= ~core_rst_d;
    end else if (POLL_DIS_WR_I) begin
      POLL_EN_O <= ~POLL_DIS_I;
    end
  end

  // Interface mode field
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode_q <= fdc_ctl_pkg::CFG_MODE_RST;
    end else if (CFG_WR_I) begin
      mode_q <= CFG_DATA_I[fdc_ctl_pkg::CFG_MODE_LSB +: 2];
    end
  end

  // Mode decides DMA gating and density polarity
  always_comb begin
    case (mode_q)
      fdc_ctl_pkg::MODE_ALT: begin
        gate_d = 1'b1;
        dens_d = ~DENSITY_HI_I;
      end
      fdc_ctl_pkg::MODE_M3: begin
        gate_d = dor_dma_q;
        dens_d = ~DENSITY_HI_I;
      end
      default: begin
        // AT mode, and any unused code
        gate_d = dor_dma_q;
        dens_d = DENSITY_HI_I;
      end
    endcase
  end

  // Mode outputs; density held high while the pin reset is on
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      DMA_INT_EN_O <= 1'b0;
      DENSITY_SELECT_OUTPUT_O <= fdc_ctl_pkg::DENSITY_SELECT_OUTPUT_RST;
      MODE_O <= fdc_ctl_pkg::CFG_MODE_RST;
      DOR_RST_O <= 1'b1;
      CORE_RST_O <= 1'b1;
    end else begin
      DMA_INT_EN_O <= gate_d;
      DENSITY_SELECT_OUTPUT_O <= dens_d;
      MODE_O <= mode_q;
      DOR_RST_O <= dor_rst_q;
      CORE_RST_O <= core_rst_q;
    end
  end

  // Track comparison for the ID field
  assign track_diff = ID_VALID_I & (ID_TRACK_I != CUR_TRACK_I);

  // Sticky flags; an event beats a same-cycle clear, reset clears all
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cm_q <= 1'b0;
      dd_q <= 1'b0;
      wc_q <= 1'b0;
      bc_q <= 1'b0;
      md_q <= 1'b0;
    end else if (core_rst_q) begin
      cm_q <= 1'b0;
      dd_q <= 1'b0;
      wc_q <= 1'b0;
      bc_q <= 1'b0;
      md_q <= 1'b0;
    end else begin
      cm_q <= (READ_DELETED_I ? MARK_NORMAL_I : MARK_DELETED_I)
              | (cm_q & ~STATUS_CLR_I);
      dd_q <= CRC_ERR_I | (dd_q & ~STATUS_CLR_I);
      wc_q <= track_diff | (wc_q & ~STATUS_CLR_I);
      bc_q <= (track_diff & (ID_TRACK_I == fdc_ctl_pkg::BAD_TRACK_NUM))
              | (bc_q & ~STATUS_CLR_I);
      md_q <= MARK_MISSING_I | (md_q & ~STATUS_CLR_I);
    end
  end

  // Assemble both status bytes
  always_comb begin
    st2_d = 8'h00;
    st2_d[fdc_ctl_pkg::ST2_CM_BIT] = cm_q;
    st2_d[fdc_ctl_pkg::ST2_DD_BIT] = dd_q;
    st2_d[fdc_ctl_pkg::ST2_WC_BIT] = wc_q;
    st2_d[fdc_ctl_pkg::ST2_BC_BIT] = bc_q;
    st2_d[fdc_ctl_pkg::ST2_MD_BIT] = md_q;
    st3_d = fdc_ctl_pkg::ST3_FIXED;
    st3_d[fdc_ctl_pkg::ST3_WP_BIT] = pin_q[1];
    st3_d[fdc_ctl_pkg::ST3_T0_BIT] = pin_q[0];
    st3_d[fdc_ctl_pkg::ST3_HD_BIT] = HEAD_SEL_I;
    st3_d[fdc_ctl_pkg::ST3_DS_LSB +: 2] = {DRIVE_SEL_HI_I, DRIVE_SEL_LO_I};
  end

  // Status byte outputs and result phase data register
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ST2_O <= fdc_ctl_pkg::BYTE_RST;
      ST3_O <= fdc_ctl_pkg::ST3_FIXED;
      DATA_O <= fdc_ctl_pkg::BYTE_RST;
    end else begin
      ST2_O <= st2_d;
      ST3_O <= st3_d;
      if (RESULT_RD_I) begin
        // Selected byte appears the cycle after the read strobe
        DATA_O <= (RESULT_SEL_I == fdc_ctl_pkg::RES_SEL_ST3) ? st3_d : st2_d;
      end
    end
  end

endmodule
`default_nettype wire

// ===== sim/fdc_drive_model.sv
// Floppy drive model: write protect and track zero pin levels
`timescale 1ns/100ps
`default_nettype none
module fdc_drive_model (
  input wire logic clk_i, // Bench clock
  input wire logic [1:0] set_i, // Wanted write protect, track zero
  output logic write_prot_o, // Write protect pin
  output logic track_zero_o // Track zero pin
);
  // Sensors settle one edge after the bench asks, as a real drive lags
  always_ff @(posedge clk_i) begin
    write_prot_o <= set_i[1];
    track_zero_o <= set_i[0];
  end
endmodule
`default_nettype wire

// ===== sim/fdc_status_reset_mode_monitor.sv
// Checker for the floppy status, reset and mode logic
`timescale 1ns/100ps
`default_nettype none
module fdc_status_reset_mode_monitor (
  input wire logic CLK_I, RSTN_I, DOR_WR_I, DSR_WR_I, READ_DELETED_I, // Clock, reset, strobes
  input wire logic MARK_NORMAL_I, MARK_DELETED_I, ID_VALID_I, // Event pulses
  input wire logic RESULT_RD_I, RESULT_SEL_I, // Result read
  input wire logic HEAD_SEL_I, DRIVE_SEL_HI_I, DRIVE_SEL_LO_I, // Select levels
  input wire logic [7:0] DOR_DATA_I, DSR_DATA_I, ID_TRACK_I, CUR_TRACK_I, // Data
  input wire logic [7:0] DATA_O, ST2_O, ST3_O, // Result bytes
  input wire logic CORE_RST_O, CFG_CLR_O, POLL_EN_O, DOR_RST_O // Reset outputs
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  property p_st2; ST2_O[7] == 1'b0 && ST2_O[3:2] == 2'h0; endproperty
  a_st2: assert property (p_st2) else $error("st2 fixed bits wrong");
  property p_st3; ST3_O[7] == 1'b0 && ST3_O[5] && ST3_O[3]; endproperty
  a_st3: assert property (p_st3) else $error("st3 fixed bits wrong");
  property p_cm;
    (READ_DELETED_I ? MARK_NORMAL_I : MARK_DELETED_I) && !CORE_RST_O |-> ##[1:2] ST2_O[6];
  endproperty
  a_cm: assert property (p_cm) else $error("control mark missing");
  property p_bad;
    ID_VALID_I && ID_TRACK_I == 8'hFF && CUR_TRACK_I != 8'hFF && !CORE_RST_O
      |-> ##[1:2] ST2_O[1] && ST2_O[4];
  endproperty
  a_bad: assert property (p_bad) else $error("bad track flags missing");
  // The cycle after a pin reset still shows the reset byte, so skip it
  property p_sel;
    $past(RSTN_I) |-> ST3_O[2:0] == $past({HEAD_SEL_I, DRIVE_SEL_HI_I, DRIVE_SEL_LO_I});
  endproperty
  a_sel: assert property (p_sel) else $error("select bits wrong");
  property p_dor; DOR_WR_I |-> ##2 DOR_RST_O == $past(DOR_DATA_I[2], 2); endproperty
  a_dor: assert property (p_dor) else $error("reset bit not taken");
  property p_hold; DOR_RST_O && $past(DOR_RST_O) |-> CORE_RST_O; endproperty
  a_hold: assert property (p_hold) else $error("core left reset early");
  property p_clr; $fell(DOR_RST_O) |-> CFG_CLR_O && POLL_EN_O; endproperty
  a_clr: assert property (p_clr) else $error("exit did not clear");
  property p_dsr;
    DSR_WR_I && DSR_DATA_I[7] && !DOR_RST_O |-> ##[1:3] CORE_RST_O ##[1:3] !CORE_RST_O;
  endproperty
  a_dsr: assert property (p_dsr) else $error("rate reset not a pulse");
  // Data register and second byte load from the same value on the read edge
  property p_read; RESULT_RD_I && !RESULT_SEL_I |=> DATA_O == ST2_O; endproperty
  a_read: assert property (p_read) else $error("result byte wrong");
  c_clr: cover property (CFG_CLR_O);
  c_bad: cover property (ST2_O[1]);
  c_soft: cover property (CORE_RST_O && !DOR_RST_O);
endmodule
bind fdc_status_reset_mode fdc_status_reset_mode_monitor u_monitor (.*);
`default_nettype wire

// ===== sim/floppy_status_reset_mode_logic_bench.sv
// Self-checking bench for the floppy status, reset and mode logic
`timescale 1ns/100ps
`default_nettype none
module floppy_status_reset_mode_logic_bench;
  logic clk = 1'b0, rstn = 1'b0, clr = 1'b0, rdel = 1'b0, rd = 1'b0, sel = 1'b0, rd_d = 1'b0;
  logic [2:0] stb = 3'h0; // Output, rate, config write strobes
  logic [4:0] evt = 5'h00; // Normal, deleted, missing, crc, id pulses
  logic [3:0] lvl = 4'h0; // Head, drive high, drive low, density
  logic [1:0] pins = 2'h0; // Drive pin requests
  logic [7:0] wd = 8'h00, id_trk = 8'h00, cur_trk = 8'h00, dat, st2, st3;
  logic wp, t0, core_rst, pwx, dor_rst, dma_en, density_select_output, pe;
  logic pwr = 1'b0, pdis = 1'b0; // Configure polling write and value
  logic [1:0] mode, m;
  logic [7:0] q[$]; // Expected result bytes
  logic [31:0] r;
  int fails = 0, checked = 0, seed = 71788, i;
  always #5 clk = ~clk;
  fdc_drive_model u_fdc_drive_model (.clk_i(clk), .set_i(pins), .write_prot_o(wp),
    .track_zero_o(t0));
  fdc_status_reset_mode u_fdc_status_reset_mode (.CLK_I(clk), .RSTN_I(rstn),
    .DOR_WR_I(stb[0]), .DOR_DATA_I(wd), .DSR_WR_I(stb[1]), .DSR_DATA_I(wd),
    .CFG_WR_I(stb[2]), .CFG_DATA_I(wd), .POLL_DIS_WR_I(pwr), .POLL_DIS_I(pdis),
    .STATUS_CLR_I(clr), .READ_DELETED_I(rdel), .MARK_NORMAL_I(evt[0]),
    .MARK_DELETED_I(evt[1]), .MARK_MISSING_I(evt[2]), .CRC_ERR_I(evt[3]),
    .ID_VALID_I(evt[4]), .ID_TRACK_I(id_trk), .CUR_TRACK_I(cur_trk), .WRITE_PROT_I(wp),
    .TRACK_ZERO_I(t0), .HEAD_SEL_I(lvl[3]), .DRIVE_SEL_HI_I(lvl[2]),
    .DRIVE_SEL_LO_I(lvl[1]), .DENSITY_HI_I(lvl[0]), .RESULT_RD_I(rd),
    .RESULT_SEL_I(sel), .DATA_O(dat), .ST2_O(st2), .ST3_O(st3), .CORE_RST_O(core_rst),
    .PWRDN_EXIT_O(pwx), .CFG_CLR_O(), .POLL_EN_O(pe), .DOR_RST_O(dor_rst),
    .DMA_INT_EN_O(dma_en), .DENSITY_SELECT_OUTPUT_O(density_select_output), .MODE_O(mode));
  // Counts and reports one comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Register write: one strobe cycle, then time to settle
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    stb <= s;
    wd <= d;
    @(posedge clk);
    stb <= 3'h0;
    tick(3);
  endtask
  // Result read; expectation queued for the watcher
  task automatic rdb(input logic s, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    sel <= s;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    tick(2);
  endtask
  // Clear flags, fire one event, read the second byte back
  task automatic ev(input logic [4:0] e, input logic d, input logic [7:0] x);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    rdel <= d;
    evt <= e;
    @(posedge clk);
    evt <= 5'h00;
    tick(3);
    rdb(1'b0, x);
  endtask
  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watcher: the byte after each read meets the oldest expectation
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) chk(dat, q.pop_front());
  end
  initial begin
    tick(4);
    chk(core_rst, 1'b1);
    chk(pwx, 1'b1);
    @(posedge clk);
    rstn <= 1'b1;
    tick(3);
    chk(core_rst, 1'b1);
    wr(3'h1, 8'h08);
    chk(core_rst, 1'b0);
    chk(pe, 1'b1);
    @(posedge clk);
    pwr <= 1'b1;
    pdis <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    tick(2);
    chk(pe, 1'b0);
    $display("reset test done");
    ev(5'h02, 1'b0, 8'h40);
    ev(5'h01, 1'b1, 8'h40);
    ev(5'h01, 1'b0, 8'h00);
    ev(5'h04, 1'b0, 8'h01);
    r = $random(seed);
    @(posedge clk);
    cur_trk <= {1'b0, r[6:0]};
    id_trk <= 8'hFF;
    ev(5'h10, 1'b0, 8'h12);
    @(posedge clk);
    id_trk <= cur_trk + 8'h01;
    ev(5'h10, 1'b0, 8'h10);
    @(posedge clk);
    id_trk <= cur_trk;
    ev(5'h10, 1'b0, 8'h00);
    ev(5'h08, 1'b0, 8'h20);
    $display("second byte test done");
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      @(posedge clk);
      pins <= r[1:0];
      lvl <= r[5:2];
      tick(6);
      rdb(1'b1, {1'b0, r[1], 1'b1, r[0], 1'b1, r[5:3]});
    end
    for (i = 0; i < 3; i++) begin
      m = (i == 0) ? fdc_ctl_pkg::MODE_AT : (i == 1) ? fdc_ctl_pkg::MODE_ALT : fdc_ctl_pkg::MODE_M3;
      wr(3'h4, {4'h0, m, 2'h0});
      wr(3'h1, 8'h00);
      chk(mode, m);
      chk(dma_en, m == fdc_ctl_pkg::MODE_ALT);
      chk(density_select_output, (m == fdc_ctl_pkg::MODE_AT) ? lvl[0] : !lvl[0]);
      wr(3'h1, 8'h08);
      chk(dma_en, 1'b1);
    end
    $display("mode test done");
    @(posedge clk);
    stb <= 3'h2;
    wd <= 8'h80;
    @(posedge clk);
    stb <= 3'h0;
    for (i = 0; i < 8 && core_rst !== 1'b1; i++) @(posedge clk);
    if (i == 8) begin
      fails++;
      end_sim();
    end
    tick(4);
    chk(core_rst, 1'b0);
    rdb(1'b0, 8'h00);
    wr(3'h1, 8'h04);
    wr(3'h2, 8'h80);
    chk(core_rst, 1'b1);
    wr(3'h1, 8'h08);
    chk(core_rst, 1'b0);
    chk(pe, 1'b1);
    @(posedge clk);
    rstn <= 1'b0;
    tick(2);
    chk(dor_rst, 1'b1);
    chk(st2, 8'h00);
    @(posedge clk);
    rstn <= 1'b1;
    tick(3);
    chk(core_rst, 1'b1);
    $display("soft reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
